// *** hdl/hcp_cfg.svh ***
/*
 * Constants of the host control port: register offsets, field positions,
 * reset values and serial frame bit counts.
 * Assumes it is included by bare name, after hcp_pkg is compiled.
 */
`ifndef HCP_CFG_SVH
`define HCP_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define HCP_OFF_MASK0      8'h11
`define HCP_OFF_MASK1      8'h12
`define HCP_OFF_STAT0      8'h16
`define HCP_OFF_STAT1      8'h17
`define HCP_OFF_GCF        8'h40
`define HCP_OFF_CHSUM      8'h80

// ----------------------------------------------------------------------
// global configuration fields and reset values
// ----------------------------------------------------------------------
`define HCP_GCF_GMASK_BIT  2
`define HCP_GCF_PIN_LSB    0
`define HCP_RST_MASK       8'hff
`define HCP_RST_GCF        8'h00
`define HCP_RST_STAT       8'h00

// ----------------------------------------------------------------------
// serial frame: bit counter values at which each phase ends
// ----------------------------------------------------------------------
`define HCP_SER_ADDR_END   6'h08
`define HCP_SER_WDAT_END   6'h10
`define HCP_SER_RLOAD      6'h18
`define HCP_SER_CNT_MAX    6'h3f
`define HCP_SRD_WAIT       2'h2

`endif

// *** hdl/hcp_pkg.sv ***
/*
 * Types of the host control port.
 * Assumes nothing of its surroundings.
 */
package hcp_pkg;

   // interrupt pin drive, in the order of the two-bit field values
   typedef enum logic [1:0] {
      HCP_PIN_OD,
      HCP_PIN_PP_LOW,
      HCP_PIN_PP_HIGH,
      HCP_PIN_PP_HIGH2
   } hcp_pin_mode_type;

   typedef enum logic [1:0] {
      HCP_P_IDLE,
      HCP_P_WRITE,
      HCP_P_READ
   } hcp_pstate_type;

endpackage : hcp_pkg

// *** hdl/hcp_reg_if.sv ***
/*
 * Carrier between the port logic and the register file.
 * Assumes both ends run on ref_clk_i.
 */
`timescale 1ns/1ns
interface hcp_reg_if;
   logic                      wr_en;
   logic [7:0]                wr_addr;
   logic [7:0]                wr_data;
   logic                      rd_done;
   logic [7:0]                rd_addr;
   logic [7:0]                rd_data;
   logic                      irq_req;
   hcp_pkg::hcp_pin_mode_type pin_mode;

   modport core (output wr_en, wr_addr, wr_data, rd_done, rd_addr,
                 input  rd_data, irq_req, pin_mode);
   modport regs (input  wr_en, wr_addr, wr_data, rd_done, rd_addr,
                 output rd_data, irq_req, pin_mode);
endinterface : hcp_reg_if

// *** hdl/hcp_regs.sv ***
/*
 * Register file: interrupt masks, sticky status, global configuration,
 * channel summary and the merged interrupt request.
 * Assumes irq_src_i pulses come from logic on ref_clk_i.
 */
`timescale 1ns/1ns
`include "hcp_cfg.svh"
module hcp_regs (
   input  wire logic  ref_clk_i,
   input  wire logic  nrst_i,
   input  wire logic  [15:0] irq_src_i,
   hcp_reg_if.regs    bus
);
   logic [7:0] mask0_r;
   logic [7:0] mask1_r;
   logic [7:0] stat0_r;
   logic [7:0] stat1_r;
   logic [7:0] gcf_r;
   logic [7:0] rd_data_r;
   logic       irq_r;
   logic [7:0] chsum;

   // set wins over the read-clear
   function automatic logic [7:0] stat_next(input logic [7:0] cur,
      input logic [7:0] src, input logic clr, input logic [7:0] seen);
      stat_next = (cur & ~(clr ? seen : 8'h00)) | src;
   endfunction : stat_next

   // channel c owns bits 2c and 2c+1 of both status registers
   function automatic logic [7:0] summary(input logic [7:0] s0,
      input logic [7:0] s1);
      logic [7:0] r;
      r = 8'h00;
      for (int c = 0; c < 4; c++) begin
         r[c] = |s0[2*c +: 2] | |s1[2*c +: 2];
      end
      summary = r;
   endfunction : summary

   assign chsum = summary(stat0_r & ~mask0_r, stat1_r & ~mask1_r); // [RQ9]

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         mask0_r <= `HCP_RST_MASK;
         mask1_r <= `HCP_RST_MASK;
         gcf_r   <= `HCP_RST_GCF;
      end else if (bus.wr_en) begin
         case (bus.wr_addr)
            `HCP_OFF_MASK0: mask0_r <= bus.wr_data; // [RQ8]
            `HCP_OFF_MASK1: mask1_r <= bus.wr_data; // [RQ8]
            `HCP_OFF_GCF:   gcf_r   <= bus.wr_data;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         stat0_r <= `HCP_RST_STAT;
         stat1_r <= `HCP_RST_STAT;
      end else begin
         stat0_r <= stat_next(stat0_r, irq_src_i[7:0], bus.rd_done &&
                    bus.rd_addr == `HCP_OFF_STAT0, rd_data_r); // [RQ9]
         stat1_r <= stat_next(stat1_r, irq_src_i[15:8], bus.rd_done &&
                    bus.rd_addr == `HCP_OFF_STAT1, rd_data_r); // [RQ9]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         rd_data_r <= 8'h00;
      end else begin
         case (bus.rd_addr)
            `HCP_OFF_MASK0: rd_data_r <= mask0_r;
            `HCP_OFF_MASK1: rd_data_r <= mask1_r;
            `HCP_OFF_STAT0: rd_data_r <= stat0_r;
            `HCP_OFF_STAT1: rd_data_r <= stat1_r;
            `HCP_OFF_GCF:   rd_data_r <= gcf_r;
            `HCP_OFF_CHSUM: rd_data_r <= chsum;
            default:        rd_data_r <= 8'h00;
         endcase
      end
   end

   // one merged request; the global mask overrides every source
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= !gcf_r[`HCP_GCF_GMASK_BIT] && |chsum; // [RQ6] [RQ7]
      end
   end

   assign bus.rd_data  = rd_data_r;
   assign bus.irq_req  = irq_r;
   assign bus.pin_mode = hcp_pkg::hcp_pin_mode_type'(
                         gcf_r[`HCP_GCF_PIN_LSB +: 2]); // [RQ10]
endmodule : hcp_regs

// *** hdl/hcp_top.sv ***
/*
 * Host control port of the line interface unit: serial shift-clocked
 * link, parallel 8-bit bus in two strobe styles, and the interrupt pin.
 * Assumes the host keeps cs_n_i high between accesses, holds the
 * mode and style straps steady, and that irq_src_i comes from logic
 * on ref_clk_i. All parallel pins are asynchronous to ref_clk_i.
 */
// Functional notes
// [RQ1] serial input bits are captured on rising shift-clock edges
// [RQ2] single-strobe style: select line low writes, high reads
// [RQ3] dual-strobe style: write strobe low starts a write cycle
// [RQ4] a dual-strobe write latches the eight data-bus bits
// [RQ5] serial output shifts out register bits on the active edge
// [RQ6] one interrupt output merges every internal source
// [RQ7] global mask bit set suppresses the interrupt for all sources
// [RQ8] two mask registers mask each source separately
// [RQ9] status reported by channel summary and two status registers
// [RQ10] two-bit field picks push-pull high, push-pull low, open drain
// [RQ11] data bus driven only during reads, otherwise released
// [RQ12] serial output changes on rising edge if select low, else falling
// [RQ13] host takes chip select low per access, holds it until done
// [RQ14] style select low picks single strobe, high picks dual strobe
`timescale 1ns/1ns
`include "hcp_cfg.svh"
module hcp_top #(
   parameter int SRC_W = 16
) (
   input  wire logic              ref_clk_i,
   input  wire logic              nrst_i,
   input  wire logic              sclk_i,
   input  wire logic              host_serial_i,
   input  wire logic              bus_style_select_i,
   input  wire logic              shift_edge_select_i,
   input  wire logic              cs_n_i,
   input  wire logic              rw_wr_sin_i,
   input  wire logic              ds_rd_n_i,
   input  wire logic [7:0]        addr_i,
   input  wire logic [7:0]        data_i,
   output logic      [7:0]        data_o,
   output logic                   data_oe_n_o,
   output logic                   serial_out_pin_o,
   output logic                   irq_o,
   output logic                   irq_oe_n_o,
   input  wire logic [SRC_W-1:0]  irq_src_i
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   localparam int SYNC_W = 24;

   hcp_reg_if                 rif ();

   // shift-clock domain
   logic [5:0]                s_cnt_r;
   logic                      s_rw_r;
   logic [7:0]                s_addr_r;
   logic [7:0]                s_wdata_r;
   logic                      s_wreq_r;
   logic                      s_rreq_r;
   logic                      s_ack_m_r;
   logic                      s_ack_r;
   logic [7:0]                s_shift_r;
   logic                      sout_pos_r;
   logic                      sout_neg_r;
   logic [7:0]                s_load;

   // reference domain
   logic [SYNC_W-1:0]         in_m_r;
   logic [SYNC_W-1:0]         in_s_r;
   logic                      serial_s;
   logic                      style_s;
   logic                      edge_s;
   logic                      rreq_s;
   logic                      wreq_s;
   logic                      cs_n_s;
   logic                      rw_wr_s;
   logic                      ds_rd_s;
   logic [7:0]                addr_s;
   logic [7:0]                data_s;
   logic                      wreq_d_r;
   logic                      rreq_d_r;
   logic                      wreq_rise;
   logic                      rreq_rise;
   logic [1:0]                srd_cnt_r;
   logic                      srd_busy_r;
   logic                      ack_r;
   logic [7:0]                r_rdata_r;
   logic                      edge_sel_r;
   logic                      p_wr_act;
   logic                      p_rd_act;
   hcp_pkg::hcp_pstate_type   p_state_r;
   logic                      wr_en_r;
   logic [7:0]                wr_addr_r;
   logic [7:0]                wr_data_r;
   logic                      rd_done_r;
   logic [7:0]                rd_addr_r;
   logic [7:0]                data_o_r;
   logic                      data_oe_n_r;
   logic                      irq_o_r;
   logic                      irq_oe_n_r;

   // ------------------------------------------------------------------
   // serial link, shift-clock domain
   // ------------------------------------------------------------------
   // the frame is cleared by chip select going high, so nothing here
   // counts on shift-clock edges outside a frame. frame layout, msb
   // first: direction bit (1 reads), 8 address bits, then either 8
   // write bits or 15 idle bits and 8 read bits driven out.
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         s_cnt_r <= 6'h00;
      end else if (s_cnt_r != `HCP_SER_CNT_MAX) begin
         s_cnt_r <= s_cnt_r + 6'h01;
      end
   end

   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         s_rw_r    <= 1'b0;
         s_addr_r  <= 8'h00;
         s_wdata_r <= 8'h00;
      end else if (s_cnt_r == 6'h00) begin
         s_rw_r <= rw_wr_sin_i; // [RQ1]
      end else if (s_cnt_r <= `HCP_SER_ADDR_END) begin
         s_addr_r <= {s_addr_r[6:0], rw_wr_sin_i}; // [RQ1]
      end else if (!s_rw_r && s_cnt_r <= `HCP_SER_WDAT_END) begin
         s_wdata_r <= {s_wdata_r[6:0], rw_wr_sin_i}; // [RQ1]
      end
   end

   // request levels; address and data stand still while they are high
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         s_wreq_r <= 1'b0;
         s_rreq_r <= 1'b0;
      end else begin
         if (!s_rw_r && s_cnt_r == `HCP_SER_WDAT_END) begin
            s_wreq_r <= 1'b1;
         end
         if (s_rw_r && s_cnt_r == `HCP_SER_ADDR_END) begin
            s_rreq_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         s_ack_m_r <= 1'b0;
         s_ack_r   <= 1'b0;
      end else begin
         s_ack_m_r <= ack_r;
         s_ack_r   <= s_ack_m_r;
      end
   end

   // read data is only sampled once the acknowledge has crossed; a
   // late answer shifts out zeros rather than a torn word
   assign s_load = s_ack_r ? r_rdata_r : 8'h00;

   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         s_shift_r <= 8'h00;
         sout_pos_r <= 1'b0;
      end else if (s_rw_r && s_cnt_r == `HCP_SER_RLOAD) begin
         sout_pos_r <= s_load[7]; // [RQ5]
         s_shift_r <= {s_load[6:0], 1'b0};
      end else if (s_rw_r && s_cnt_r > `HCP_SER_RLOAD) begin
         sout_pos_r <= s_shift_r[7]; // [RQ5]
         s_shift_r <= {s_shift_r[6:0], 1'b0};
      end
   end

   always_ff @(negedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         sout_neg_r <= 1'b0;
      end else begin
         sout_neg_r <= sout_pos_r; // [RQ12]
      end
   end

   // the edge select is a strap; its synchronised copy only steers the
   // pin mux and never enters shift-clock logic
   assign serial_out_pin_o = edge_sel_r ? sout_neg_r : sout_pos_r; // [RQ12]

   // ------------------------------------------------------------------
   // pin synchronisers, reference domain
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         in_m_r <= {SYNC_W{1'b0}};
         in_s_r <= {SYNC_W{1'b0}};
      end else begin
         in_m_r <= {host_serial_i, bus_style_select_i,
                    shift_edge_select_i, s_rreq_r, s_wreq_r, cs_n_i,
                    rw_wr_sin_i, ds_rd_n_i, addr_i, data_i};
         in_s_r <= in_m_r;
      end
   end

   assign {serial_s, style_s, edge_s, rreq_s, wreq_s, cs_n_s,
           rw_wr_s, ds_rd_s, addr_s, data_s} = in_s_r;

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         wreq_d_r   <= 1'b0;
         rreq_d_r   <= 1'b0;
         edge_sel_r <= 1'b0;
      end else begin
         wreq_d_r   <= wreq_s;
         rreq_d_r   <= rreq_s;
         edge_sel_r <= edge_s;
      end
   end

   assign wreq_rise = serial_s && wreq_s && !wreq_d_r;
   assign rreq_rise = serial_s && rreq_s && !rreq_d_r;

   // ------------------------------------------------------------------
   // parallel access decode
   // ------------------------------------------------------------------
   // dual strobe: separate active-low write and read strobes; single
   // strobe: one data strobe qualified by the direction line
   assign p_wr_act = !serial_s && !cs_n_s && // [RQ13]
                     (style_s ? !rw_wr_s : // [RQ3] [RQ14]
                                (!ds_rd_s && !rw_wr_s)); // [RQ2]
   assign p_rd_act = !serial_s && !cs_n_s &&
                     (style_s ? !ds_rd_s : // [RQ14]
                                (!ds_rd_s && rw_wr_s)); // [RQ2]

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         p_state_r <= hcp_pkg::HCP_P_IDLE;
      end else begin
         case (p_state_r)
            hcp_pkg::HCP_P_IDLE: begin
               if (p_wr_act) begin
                  p_state_r <= hcp_pkg::HCP_P_WRITE;
               end else if (p_rd_act) begin
                  p_state_r <= hcp_pkg::HCP_P_READ;
               end
            end
            hcp_pkg::HCP_P_WRITE: begin
               if (!p_wr_act) begin
                  p_state_r <= hcp_pkg::HCP_P_IDLE;
               end
            end
            hcp_pkg::HCP_P_READ: begin
               if (!p_rd_act) begin
                  p_state_r <= hcp_pkg::HCP_P_IDLE;
               end
            end
            default: p_state_r <= hcp_pkg::HCP_P_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // serial read service
   // ------------------------------------------------------------------
   // waits for the register file's registered read data, then raises
   // the acknowledge level until the request falls with the frame
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         srd_cnt_r  <= 2'h0;
         srd_busy_r <= 1'b0;
         ack_r      <= 1'b0;
         r_rdata_r  <= 8'h00;
      end else if (!rreq_s) begin
         srd_cnt_r  <= 2'h0;
         srd_busy_r <= 1'b0;
         ack_r      <= 1'b0;
      end else if (rreq_rise) begin
         srd_busy_r <= 1'b1;
         srd_cnt_r  <= 2'h0;
      end else if (srd_busy_r && srd_cnt_r == `HCP_SRD_WAIT) begin
         r_rdata_r  <= rif.rd_data; // [RQ5]
         ack_r      <= 1'b1;
         srd_busy_r <= 1'b0;
      end else if (srd_busy_r) begin
         srd_cnt_r <= srd_cnt_r + 2'h1;
      end
   end

   // ------------------------------------------------------------------
   // register file requests
   // ------------------------------------------------------------------
   // the two hosts modes never run together, so a single set of
   // request registers serves both
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         wr_en_r   <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
         rd_done_r <= 1'b0;
         rd_addr_r <= 8'h00;
      end else begin
         wr_en_r   <= 1'b0;
         rd_done_r <= 1'b0;
         if (wreq_rise) begin
            wr_en_r   <= 1'b1;
            wr_addr_r <= s_addr_r;
            wr_data_r <= s_wdata_r;
         end else if (p_state_r == hcp_pkg::HCP_P_WRITE) begin
            if (p_wr_act) begin
               wr_addr_r <= addr_s;
               wr_data_r <= data_s; // [RQ4]
            end else begin
               wr_en_r <= 1'b1;
            end
         end
         if (rreq_rise) begin
            rd_addr_r <= s_addr_r;
         end else if (p_rd_act && p_state_r == hcp_pkg::HCP_P_IDLE) begin
            rd_addr_r <= addr_s;
         end
         // status clears once the host has had its copy
         if (srd_busy_r && srd_cnt_r == `HCP_SRD_WAIT) begin
            rd_done_r <= 1'b1;
         end else if (p_state_r == hcp_pkg::HCP_P_READ && !p_rd_act) begin
            rd_done_r <= 1'b1;
         end
      end
   end

   assign rif.wr_en   = wr_en_r;
   assign rif.wr_addr = wr_addr_r;
   assign rif.wr_data = wr_data_r;
   assign rif.rd_done = rd_done_r;
   assign rif.rd_addr = rd_addr_r;

   hcp_regs i_hcp_regs (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .irq_src_i (irq_src_i),
      .bus       (rif.regs)
   );

   // ------------------------------------------------------------------
   // data bus drive
   // ------------------------------------------------------------------
   // released as soon as the read strobe is seen gone; the pin lags
   // the strobe by the two synchroniser stages and the output register
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         data_o_r    <= 8'h00;
         data_oe_n_r <= 1'b1;
      end else if (p_state_r == hcp_pkg::HCP_P_READ && p_rd_act) begin
         data_o_r    <= rif.rd_data;
         data_oe_n_r <= 1'b0; // [RQ11]
      end else begin
         data_oe_n_r <= 1'b1; // [RQ11]
      end
   end

   assign data_o      = data_o_r;
   assign data_oe_n_o = data_oe_n_r;

   // ------------------------------------------------------------------
   // interrupt pin
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         irq_o_r    <= 1'b0;
         irq_oe_n_r <= 1'b1;
      end else begin
         case (rif.pin_mode)
            hcp_pkg::HCP_PIN_OD: begin
               irq_o_r    <= 1'b0;
               irq_oe_n_r <= !rif.irq_req; // [RQ10]
            end
            hcp_pkg::HCP_PIN_PP_LOW: begin
               irq_o_r    <= !rif.irq_req; // [RQ10]
               irq_oe_n_r <= 1'b0;
            end
            default: begin
               irq_o_r    <= rif.irq_req; // [RQ6] [RQ10]
               irq_oe_n_r <= 1'b0;
            end
         endcase
      end
   end

   assign irq_o      = irq_o_r;
   assign irq_oe_n_o = irq_oe_n_r;

endmodule : hcp_top

// *** testbench/hcp_checker.sv ***
/* Assertions on the pins of hcp_top.
   Assumes it is bound to hcp_top and sees only its ports. */
`timescale 1ns/1ns
module hcp_checker (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic host_serial_i,
   input wire logic cs_n_i,
   input wire logic rw_wr_sin_i,
   input wire logic ds_rd_n_i,
   input wire logic data_oe_n_o,
   input wire logic serial_out_pin_o,
   input wire logic irq_o,
   input wire logic irq_oe_n_o
);
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   a_oe_needs_read: assert property (
      $fell(data_oe_n_o) |-> $past(!ds_rd_n_i && !cs_n_i, 3))
      else $error("data bus driven without a read strobe");
   a_read_rw_high: assert property (
      $fell(data_oe_n_o) |-> $past(rw_wr_sin_i, 3))
      else $error("data bus driven during a write");
   a_oe_holds: assert property (
      !data_oe_n_o && !ds_rd_n_i |=> !data_oe_n_o)
      else $error("data bus released while strobe active");
   a_oe_released: assert property (
      ds_rd_n_i [*5] |-> data_oe_n_o)
      else $error("data bus still driven after strobe");
   a_ser_no_bus: assert property (
      host_serial_i [*8] |-> data_oe_n_o)
      else $error("data bus driven in serial mode");
   a_ser_idle_low: assert property (
      cs_n_i [*2] |-> !serial_out_pin_o)
      else $error("serial output active outside a frame");
   a_read_answers: assert property (
      $fell(ds_rd_n_i) && rw_wr_sin_i && !host_serial_i
      |-> ##[3:6] !data_oe_n_o)
      else $error("parallel read not answered");
   a_reset_release: assert property (disable iff (1'b0)
      !nrst_i ##1 !nrst_i |-> data_oe_n_o && irq_oe_n_o && !irq_o)
      else $error("pins not released in reset");
endmodule : hcp_checker

// *** testbench/hcp_host.sv ***
/* Host model: drives the parallel and serial control pins.
   Assumes its tasks are called one at a time. */
`timescale 1ns/1ns
module hcp_host (
   input  wire logic       ref_clk_i,
   input  wire logic [7:0] dev_d_i,
   input  wire logic       dev_oe_n_i,
   input  wire logic       sout_i,
   output logic            sclk_o,
   output logic            mode_o,
   output logic            style_o,
   output logic            edge_o,
   output logic            cs_n_o,
   output logic            rw_o,
   output logic            ds_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      data_o
);
   // ----------
   // bus drivers
   // ----------
   logic [7:0] hv;
   // released bus shows a stale host value
   assign data_o = dev_oe_n_i ? hv : dev_d_i;

   initial begin
      {sclk_o, mode_o, style_o, edge_o} = 4'h0;
      {cs_n_o, rw_o, ds_o} = 3'h3;
      {addr_o, hv} = 16'h0000;
      #1 cs_n_o = 1'b1; // real select edge clears the serial logic
   end

   task automatic par(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
      @(posedge ref_clk_i);
      cs_n_o <= 1'b0;
      addr_o <= a;
      hv <= w ? d : 8'h96;
      rw_o <= ~w;
      ds_o <= style_o & w;
      repeat (7) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      q = data_o;
      @(posedge ref_clk_i);
      ds_o <= 1'b1;
      rw_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      cs_n_o <= 1'b1;
      hv <= ~hv;
      repeat (6) @(posedge ref_clk_i);
   endtask : par

   task automatic ser(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
      logic [16:0] f;
      f = {~w, a, d};
      q = 8'h00;
      #3 cs_n_o = 1'b0;
      rw_o = f[16];
      for (int i = 1; i <= (w ? 17 : 33); i++) begin
         #7 sclk_o = 1'b1;
         if (edge_o && i > 25) q = {q[6:0], sout_i};
         #8 sclk_o = 1'b0;
         if (!edge_o && i > 24 && i < 33) q = {q[6:0], sout_i};
         rw_o = (i < 17) ? f[16-i] : 1'b0;
      end
      #100 cs_n_o = 1'b1;
      rw_o = 1'b1;
      #60;
   endtask : ser
endmodule : hcp_host

// *** testbench/test_host_control_port_and_interrupt.sv ***
/* Self-checking bench of the host control port.
   Assumes hcp_host models the host and hcp_checker is bound below. */
`timescale 1ns/1ns
`include "hcp_cfg.svh"
module test_host_control_port_and_interrupt;
   localparam logic [1:0] ON_V [3]  = '{2'b00, 2'b00, 2'b10};
   localparam logic [1:0] OFF_V [3] = '{2'b01, 2'b10, 2'b00};
   logic        ref_clk_i = 1'b0;
   logic        nrst_i    = 1'b0;
   logic [15:0] irq_src   = 16'h0000;
   logic [7:0]  addr, d_in, d_out, q;
   logic        sclk, mode, style, edg, cs_n, rw, ds;
   logic        oe_n, sout, irq, irq_oe_n;
   int          err_total = 0;
   int          checks    = 0;
   int          cycles    = 0;

   always #10 ref_clk_i = ~ref_clk_i;

   hcp_top #(.SRC_W(16)) i_hcp_top (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sclk_i(sclk),
      .host_serial_i(mode), .bus_style_select_i(style),
      .shift_edge_select_i(edg), .cs_n_i(cs_n), .rw_wr_sin_i(rw),
      .ds_rd_n_i(ds), .addr_i(addr), .data_i(d_in), .data_o(d_out),
      .data_oe_n_o(oe_n), .serial_out_pin_o(sout), .irq_o(irq),
      .irq_oe_n_o(irq_oe_n), .irq_src_i(irq_src));

   hcp_host i_hcp_host (
      .ref_clk_i(ref_clk_i), .dev_d_i(d_out), .dev_oe_n_i(oe_n),
      .sout_i(sout), .sclk_o(sclk), .mode_o(mode), .style_o(style),
      .edge_o(edg), .cs_n_o(cs_n), .rw_o(rw), .ds_o(ds),
      .addr_o(addr), .data_o(d_in));

   // ----------
   // helpers
   // ----------
   task automatic chk(input string n, input logic [7:0] s, e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [7:0] a, d);
      if (mode) i_hcp_host.ser(w, a, d, q);
      else i_hcp_host.par(w, a, d, q);
   endtask : acc

   task automatic pulse(input int k);
      @(posedge ref_clk_i);
      irq_src <= 16'h0001 << k;
      @(posedge ref_clk_i);
      irq_src <= 16'h0000;
      repeat (5) @(negedge ref_clk_i);
   endtask : pulse

   task automatic tally_and_finish;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // ----------
   // scenarios
   // ----------
   task automatic t_reset;
      acc(0, `HCP_OFF_MASK0, 8'h00);
      chk("mask0", q, `HCP_RST_MASK);
      acc(0, `HCP_OFF_GCF, 8'h00);
      chk("gcf", q, `HCP_RST_GCF);
      acc(0, 8'h55, 8'h00);
      chk("unmapped", q, 8'h00);
   endtask : t_reset

   task automatic t_par;
      acc(1, `HCP_OFF_MASK0, 8'hfe);
      acc(0, `HCP_OFF_MASK0, 8'h00);
      chk("mask0 single", q, 8'hfe);
      @(posedge ref_clk_i);
      i_hcp_host.style_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      acc(1, `HCP_OFF_MASK1, 8'ha5);
      acc(0, `HCP_OFF_MASK1, 8'h00);
      chk("mask1 dual", q, 8'ha5);
      acc(1, `HCP_OFF_STAT0, 8'hff);
      acc(0, `HCP_OFF_STAT0, 8'h00);
      chk("stat0 ro", q, `HCP_RST_STAT);
      acc(1, `HCP_OFF_MASK1, 8'hff);
   endtask : t_par

   task automatic t_irq;
      for (int m = 0; m < 3; m++) begin
         acc(1, `HCP_OFF_GCF, 8'(m));
         pulse(0);
         chk("irq on", {6'h00, irq, irq_oe_n}, ON_V[m]);
         acc(0, `HCP_OFF_CHSUM, 8'h00);
         chk("chsum", q, 8'h01);
         acc(0, `HCP_OFF_STAT0, 8'h00);
         chk("stat0", q, 8'h01);
         repeat (4) @(negedge ref_clk_i);
         chk("irq off", {6'h00, irq, irq_oe_n}, OFF_V[m]);
      end
      acc(1, `HCP_OFF_GCF, 8'h06);
      pulse(0);
      chk("irq gmask", {6'h00, irq, irq_oe_n}, 8'h00);
      acc(0, `HCP_OFF_STAT0, 8'h00);
      chk("stat0 gmask", q, 8'h01);
      acc(1, `HCP_OFF_GCF, 8'h02);
      pulse(1);
      pulse(8);
      chk("irq masked", {6'h00, irq, irq_oe_n}, 8'h00);
      acc(0, `HCP_OFF_CHSUM, 8'h00);
      chk("chsum masked", q, 8'h00);
      acc(0, `HCP_OFF_STAT0, 8'h00);
      chk("stat0 bit1", q, 8'h02);
      acc(0, `HCP_OFF_STAT1, 8'h00);
      chk("stat1 bit0", q, 8'h01);
   endtask : t_irq

   task automatic t_ser;
      @(posedge ref_clk_i);
      i_hcp_host.mode_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      acc(1, `HCP_OFF_MASK1, 8'h3c);
      repeat (20) @(posedge ref_clk_i);
      acc(0, `HCP_OFF_MASK1, 8'h00);
      chk("ser rise", q, 8'h3c);
      @(posedge ref_clk_i);
      i_hcp_host.edge_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      acc(0, `HCP_OFF_MASK1, 8'h00);
      chk("ser fall", q, 8'h3c);
   endtask : t_ser

   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         tally_and_finish;
      end
   end

   initial begin
      repeat (3) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      t_reset;
      t_par;
      t_irq;
      t_ser;
      tally_and_finish;
   end
endmodule : test_host_control_port_and_interrupt

bind hcp_top hcp_checker i_hcp_checker (
   .ref_clk_i, .nrst_i, .host_serial_i, .cs_n_i, .rw_wr_sin_i,
   .ds_rd_n_i, .data_oe_n_o, .serial_out_pin_o, .irq_o, .irq_oe_n_o);
